// ===== verilog/sfr_bank0_regs.vh
`ifndef SFR_BANK0_REGS_VH
`define SFR_BANK0_REGS_VH

// register offsets within bank 0
`define OFS_INDIRECT   5'h00
`define OFS_TIMER0_COUNT       5'h01
`define OFS_PCL        5'h02
`define OFS_STATUS     5'h03
`define OFS_FSR        5'h04
`define OFS_PORT_A_DATA      5'h05
`define OFS_PORT_B_DATA      5'h06
`define OFS_PORT_C_DATA      5'h07
`define OFS_PORT_D_DATA      5'h08
`define OFS_PORT_E_DATA      5'h09
`define OFS_PC_HIGH_WRITE_LATCH     5'h0a
`define OFS_INTERRUPT_CONTROL     5'h0b
`define OFS_PERIPHERAL_IRQ_FLAGS1       5'h0c
`define OFS_PERIPHERAL_IRQ_FLAGS2       5'h0d
`define OFS_T1LOW      5'h0e
`define OFS_T1HIGH     5'h0f
`define OFS_T1CTL      5'h10
`define OFS_TIMER2_COUNT       5'h11
`define OFS_T2CTL      5'h12
`define OFS_SYNC_SERIAL_BUFFER     5'h13
`define OFS_SSPCTL     5'h14
`define OFS_CCP1L      5'h15
`define OFS_CCP1H      5'h16
`define OFS_CCP1CTL    5'h17
`define OFS_RXCTL      5'h18
`define OFS_TXDATA     5'h19
`define OFS_RXDATA     5'h1a
`define OFS_CCP2L      5'h1b
`define OFS_CCP2H      5'h1c
`define OFS_CCP2CTL    5'h1d

// per-register attribute word: {implemented, power-on value, kept on other reset, writable}
`define ATTR_MASK      31:24
`define ATTR_POR       23:16
`define ATTR_KEEP      15:8
`define ATTR_WR        7:0

`define ATTR_NONE      32'h00_00_00_00
`define ATTR_BYTE_KEEP 32'hff_00_ff_ff
`define ATTR_STATUS    32'hff_18_1f_e7
`define ATTR_PORT_A_DATA     32'h3f_00_3f_3f
`define ATTR_PORT_E_DATA     32'h07_00_07_07
`define ATTR_PC_HIGH_WRITE_LATCH    32'h1f_00_00_1f
`define ATTR_INTERRUPT_CONTROL    32'hff_00_01_ff
`define ATTR_PERIPHERAL_IRQ_FLAGS1      32'hff_00_00_ff
`define ATTR_PERIPHERAL_IRQ_FLAGS2      32'h01_00_00_01
`define ATTR_T1CTL     32'h3f_00_3f_3f
`define ATTR_TIMER2_COUNT      32'hff_00_00_ff
`define ATTR_T2CTL     32'h7f_00_00_7f
`define ATTR_SSPCTL    32'hff_00_00_ff
`define ATTR_CCPCTL    32'h3f_00_00_3f
`define ATTR_RXCTL     32'hf7_00_01_f0
`define ATTR_TXDATA    32'hff_00_00_ff
`define ATTR_RXDATA    32'hff_00_00_00

// status bit positions
`define ST_IRP         7
`define ST_RP1         6
`define ST_RP0         5
`define ST_TO          4
`define ST_PD          3
`define ST_FLAGS       2:0

// other fields and sizes
`define PC_HIGH_WRITE_LATCH_BITS    4:0
`define PC_W           13
`define PC_ONE         13'h0001
`define PC_ZERO        13'h0000
`define JUMP_W         11
`define RXERR_BITS     2:0
`define BYTE_ZERO      8'h00
`define BYTE_ONES      8'hff
`define FLAGS_ONES     8'h07
`define NUM_REGS       32
`define BANK0          2'b00
`define LOW_REGION     2'b00

`endif

// ===== verilog/special_function_register_bank0.v
`timescale 1ns/1ps
`include "sfr_bank0_regs.vh"

// What this block does
// [RULE1] unmapped addresses and bits read zero, ignore writes
// [RULE2] core registers share one storage across banks
// [RULE3] pc high only through latch, loaded on update
// [RULE4] separate power-on and other-reset values
// [RULE5] timer1 count as low and high bytes
// [RULE6] software keeps bank high bits, bit six clear
// [RULE7] software keeps brown-out flag set on variant
// [RULE8] usart data registers clear on every reset
// [RULE9] indirect port accesses memory at pointer address
// [RULE10] port write sets latch, read returns pins
module special_function_register_bank0 (
	input  wire         clk,
	input  wire         nrst,
	input  wire         external_reset_pin,
	input  wire         watchdog_timeout,
	input  wire [6:0]   acc_addr,
	input  wire         acc_rd,
	input  wire         acc_wr,
	input  wire [7:0]   acc_wdata,
	output reg  [7:0]   rd_data_q,
	output reg          rd_valid_q,
	output reg  [8:0]   mem_addr_q,
	output reg          mem_re_q,
	output reg          mem_we_q,
	output reg  [7:0]   mem_wdata_q,
	input  wire [7:0]   mem_rdata,
	output reg  [12:0]  pc_q,
	input  wire         pc_inc,
	input  wire         pc_jump,
	input  wire [10:0]  pc_jump_target,
	input  wire         alu_flags_we,
	input  wire [2:0]   alu_flags,
	input  wire         sleep_entered,
	input  wire         watchdog_cleared,
	input  wire [39:0]  port_pins,
	input  wire [7:0]   peripheral_irq_flags1_set,
	input  wire         peripheral_irq_flags2_set,
	input  wire         timer0_load,
	input  wire [7:0]   timer0_value,
	input  wire         timer1_load,
	input  wire [15:0]  timer1_value,
	input  wire         timer2_load,
	input  wire [7:0]   timer2_value,
	input  wire         serial_load,
	input  wire [7:0]   serial_data,
	input  wire         rx_load,
	input  wire [7:0]   rx_data,
	input  wire [2:0]   rx_err,
	output reg          tx_written_q,
	output reg  [255:0] sfr_image_q
);

	// attribute lookup per bank-0 offset
	function [31:0] attr;
		input [4:0] a;
		begin
			case (a)
				`OFS_TIMER0_COUNT:    attr = `ATTR_BYTE_KEEP;
				`OFS_STATUS:  attr = `ATTR_STATUS;
				`OFS_FSR:     attr = `ATTR_BYTE_KEEP;
				`OFS_PORT_A_DATA:   attr = `ATTR_PORT_A_DATA;
				`OFS_PORT_B_DATA:   attr = `ATTR_BYTE_KEEP;
				`OFS_PORT_C_DATA:   attr = `ATTR_BYTE_KEEP;
				`OFS_PORT_D_DATA:   attr = `ATTR_BYTE_KEEP;
				`OFS_PORT_E_DATA:   attr = `ATTR_PORT_E_DATA;
				`OFS_PC_HIGH_WRITE_LATCH:  attr = `ATTR_PC_HIGH_WRITE_LATCH;
				`OFS_INTERRUPT_CONTROL:  attr = `ATTR_INTERRUPT_CONTROL;
				`OFS_PERIPHERAL_IRQ_FLAGS1:    attr = `ATTR_PERIPHERAL_IRQ_FLAGS1;
				`OFS_PERIPHERAL_IRQ_FLAGS2:    attr = `ATTR_PERIPHERAL_IRQ_FLAGS2;
				`OFS_T1LOW:   attr = `ATTR_BYTE_KEEP;
				`OFS_T1HIGH:  attr = `ATTR_BYTE_KEEP;
				`OFS_T1CTL:   attr = `ATTR_T1CTL;
				`OFS_TIMER2_COUNT:    attr = `ATTR_TIMER2_COUNT;
				`OFS_T2CTL:   attr = `ATTR_T2CTL;
				`OFS_SYNC_SERIAL_BUFFER:  attr = `ATTR_BYTE_KEEP;
				`OFS_SSPCTL:  attr = `ATTR_SSPCTL;
				`OFS_CCP1L:   attr = `ATTR_BYTE_KEEP;
				`OFS_CCP1H:   attr = `ATTR_BYTE_KEEP;
				`OFS_CCP1CTL: attr = `ATTR_CCPCTL;
				`OFS_RXCTL:   attr = `ATTR_RXCTL;
				`OFS_TXDATA:  attr = `ATTR_TXDATA;
				`OFS_RXDATA:  attr = `ATTR_RXDATA;
				`OFS_CCP2L:   attr = `ATTR_BYTE_KEEP;
				`OFS_CCP2H:   attr = `ATTR_BYTE_KEEP;
				`OFS_CCP2CTL: attr = `ATTR_CCPCTL;
				default:      attr = `ATTR_NONE;
			endcase
		end
	endfunction

	// registers seen from every bank
	function is_core;
		input [4:0] a;
		begin
			case (a)
				`OFS_INDIRECT: is_core = 1'b1;
				`OFS_PCL:      is_core = 1'b1;
				`OFS_STATUS:   is_core = 1'b1;
				`OFS_FSR:      is_core = 1'b1;
				`OFS_PC_HIGH_WRITE_LATCH:   is_core = 1'b1;
				`OFS_INTERRUPT_CONTROL:   is_core = 1'b1;
				default:       is_core = 1'b0;
			endcase
		end
	endfunction

	wire        other_rst;
	wire [7:0]  status;
	wire [1:0]  bank;
	wire [4:0]  idx;
	wire        core_reg;
	wire        hit;
	wire [4:0]  pofs;
	wire [4:0]  pc_high_write_latch;
	wire [7:0]  indirect_pointer;
	wire        take_rd;
	wire        take_wr;
	// decoded access kinds
	wire        addr_low;
	wire        bank_ok;
	wire        rd_indirect;
	wire        rd_direct;
	wire        wr_indirect;
	wire        wr_pcl;
	wire        wr_tx;
	wire [12:0] pc_from_write;
	wire [12:0] pc_from_jump;
	wire [12:0] pc_step;

	reg  [255:0] set_v;
	reg  [255:0] ld_m;
	reg  [255:0] ld_v;
	reg  [7:0]   rd_mux;
	reg  [31:0]  rd_attr;
	reg          ind_pend_q;

	assign other_rst = external_reset_pin | watchdog_timeout;
	assign status    = sfr_image_q[`OFS_STATUS*8 +: 8];
	assign indirect_pointer       = sfr_image_q[`OFS_FSR*8 +: 8];
	assign pc_high_write_latch    = sfr_image_q[`OFS_PC_HIGH_WRITE_LATCH*8 + 4 -: 5];
	// [RULE6] decode uses both bank bits
	assign bank      = {status[`ST_RP1], status[`ST_RP0]};
	assign idx       = acc_addr[4:0];
	assign core_reg  = is_core(idx);
	// [RULE2] core registers answer in any bank
	assign bank_ok   = (bank == `BANK0) || core_reg;
	assign addr_low  = (acc_addr[6:5] == `LOW_REGION);
	assign hit       = addr_low && bank_ok;
	assign pofs      = idx - `OFS_PORT_A_DATA;
	// other reset holds off every access
	assign take_rd   = acc_rd & hit & ~other_rst;
	assign take_wr   = acc_wr & hit & ~other_rst;

	// access kinds
	assign rd_indirect = take_rd && (idx == `OFS_INDIRECT);
	assign rd_direct   = take_rd && (idx != `OFS_INDIRECT);
	assign wr_indirect = take_wr && (idx == `OFS_INDIRECT);
	assign wr_pcl      = take_wr && (idx == `OFS_PCL);
	assign wr_tx       = take_wr && (idx == `OFS_TXDATA);

	// program counter candidates
	assign pc_from_write = {pc_high_write_latch, acc_wdata};
	assign pc_from_jump  = {pc_high_write_latch[4:3], pc_jump_target};
	assign pc_step       = pc_q + `PC_ONE;

	// hardware sources: sticky sets and direct loads
	always @* begin
		set_v = {256{1'b0}};
		ld_m  = {256{1'b0}};
		ld_v  = {256{1'b0}};
		set_v[`OFS_PERIPHERAL_IRQ_FLAGS1*8 +: 8] = peripheral_irq_flags1_set;
		set_v[`OFS_PERIPHERAL_IRQ_FLAGS2*8]      = peripheral_irq_flags2_set;
		if (alu_flags_we) begin
			ld_m[`OFS_STATUS*8 +: 3] = {3{1'b1}};
			ld_v[`OFS_STATUS*8 +: 3] = alu_flags;
		end
		if (watchdog_cleared) begin
			ld_m[`OFS_STATUS*8 + `ST_TO] = 1'b1;
			ld_m[`OFS_STATUS*8 + `ST_PD] = 1'b1;
			ld_v[`OFS_STATUS*8 + `ST_TO] = 1'b1;
			ld_v[`OFS_STATUS*8 + `ST_PD] = 1'b1;
		end else if (sleep_entered) begin
			ld_m[`OFS_STATUS*8 + `ST_TO] = 1'b1;
			ld_m[`OFS_STATUS*8 + `ST_PD] = 1'b1;
			ld_v[`OFS_STATUS*8 + `ST_TO] = 1'b1;
			ld_v[`OFS_STATUS*8 + `ST_PD] = 1'b0;
		end
		if (timer0_load) begin
			ld_m[`OFS_TIMER0_COUNT*8 +: 8] = `BYTE_ONES;
			ld_v[`OFS_TIMER0_COUNT*8 +: 8] = timer0_value;
		end
		// [RULE5] counter loads both byte registers
		if (timer1_load) begin
			ld_m[`OFS_T1LOW*8 +: 8]  = `BYTE_ONES;
			ld_v[`OFS_T1LOW*8 +: 8]  = timer1_value[7:0];
			ld_m[`OFS_T1HIGH*8 +: 8] = `BYTE_ONES;
			ld_v[`OFS_T1HIGH*8 +: 8] = timer1_value[15:8];
		end
		if (timer2_load) begin
			ld_m[`OFS_TIMER2_COUNT*8 +: 8] = `BYTE_ONES;
			ld_v[`OFS_TIMER2_COUNT*8 +: 8] = timer2_value;
		end
		if (serial_load) begin
			ld_m[`OFS_SYNC_SERIAL_BUFFER*8 +: 8] = `BYTE_ONES;
			ld_v[`OFS_SYNC_SERIAL_BUFFER*8 +: 8] = serial_data;
		end
		if (rx_load) begin
			ld_m[`OFS_RXDATA*8 +: 8] = `BYTE_ONES;
			ld_v[`OFS_RXDATA*8 +: 8] = rx_data;
			ld_m[`OFS_RXCTL*8 +: 3]  = {3{1'b1}};
			ld_v[`OFS_RXCTL*8 +: 3]  = rx_err;
		end
	end

	genvar i;
	generate
		for (i = 0; i < `NUM_REGS; i = i + 1) begin : entry
			localparam [4:0]  IDX  = i;
			localparam [31:0] A    = attr(IDX);
			localparam [7:0]  MSK  = A[`ATTR_MASK];
			localparam [7:0]  POR  = A[`ATTR_POR] & A[`ATTR_MASK];
			localparam [7:0]  WM   = A[`ATTR_WR] & A[`ATTR_MASK];
			localparam        STAT = (IDX == `OFS_STATUS);
			wire [7:0] cur;
			wire [7:0] sw;
			wire [7:0] nxt;
			wire [7:0] keep;
			wire [7:0] oth;
			wire [7:0] ld_msk;
			wire [7:0] ld_val;
			wire [7:0] hw_set;
			wire [7:0] rst_oth;
			wire       wr_i;
			assign cur  = sfr_image_q[8*i +: 8];
			// this entry's slice of the hardware sources
			assign ld_msk = ld_m[8*i +: 8];
			assign ld_val = ld_v[8*i +: 8];
			assign hw_set = set_v[8*i +: 8];
			// [RULE1] writes outside the map change nothing
			assign wr_i = take_wr & (idx == IDX);
			assign sw   = wr_i ? ((acc_wdata & WM) | (cur & ~WM)) : cur;
			// set from hardware wins over a clearing write
			assign nxt  = ((sw & ~ld_msk) | ld_val) | hw_set;
			// watchdog timeout clears the time-out flag
			assign keep = (STAT && watchdog_timeout) ?
				(A[`ATTR_KEEP] & ~(8'h01 << `ST_TO)) : A[`ATTR_KEEP];
			assign oth  = (STAT && watchdog_timeout) ?
				(POR & ~(8'h01 << `ST_TO)) : POR;
			// kept bits stay, the rest take the reset value
			assign rst_oth = ((cur & keep) | (oth & ~keep)) & MSK;
			// [RULE4] power-on set, other-reset set
			// [RULE8] data registers carry no kept bits
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					sfr_image_q[8*i +: 8] <= POR;
				end else if (other_rst) begin
					sfr_image_q[8*i +: 8] <= rst_oth;
				end else begin
					sfr_image_q[8*i +: 8] <= nxt & MSK;
				end
			end
		end
	endgenerate

	// read data selection
	always @* begin
		rd_attr = attr(idx);
		case (idx)
			`OFS_PCL:    rd_mux = pc_q[7:0];
			`OFS_TXDATA: rd_mux = `BYTE_ZERO;
			// [RULE10] port reads return pin levels
			`OFS_PORT_A_DATA,
			`OFS_PORT_B_DATA,
			`OFS_PORT_C_DATA,
			`OFS_PORT_D_DATA,
			`OFS_PORT_E_DATA:  rd_mux = port_pins[{pofs[2:0], 3'b000} +: 8] & rd_attr[`ATTR_MASK];
			// [RULE1] holes and spare bits read zero
			default:     rd_mux = sfr_image_q[{idx, 3'b000} +: 8] & rd_attr[`ATTR_MASK];
		endcase
	end

	// bus answer and indirect access path
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_q    <= `BYTE_ZERO;
			rd_valid_q   <= 1'b0;
			mem_addr_q   <= 9'h000;
			mem_re_q     <= 1'b0;
			mem_we_q     <= 1'b0;
			mem_wdata_q  <= `BYTE_ZERO;
			ind_pend_q   <= 1'b0;
			tx_written_q <= 1'b0;
		end else if (other_rst) begin
			rd_valid_q   <= 1'b0;
			mem_re_q     <= 1'b0;
			mem_we_q     <= 1'b0;
			ind_pend_q   <= 1'b0;
			tx_written_q <= 1'b0;
		end else begin
			rd_valid_q   <= 1'b0;
			mem_re_q     <= 1'b0;
			mem_we_q     <= 1'b0;
			tx_written_q <= wr_tx;
			ind_pend_q   <= 1'b0;
			if (ind_pend_q) begin
				rd_valid_q <= 1'b1;
				rd_data_q  <= mem_rdata;
			end
			// [RULE9] indirect port goes to memory
			if (rd_indirect) begin
				mem_re_q   <= 1'b1;
				mem_addr_q <= {status[`ST_IRP], indirect_pointer};
				ind_pend_q <= 1'b1;
			end else if (rd_direct) begin
				rd_valid_q <= 1'b1;
				rd_data_q  <= rd_mux;
			end
			if (wr_indirect) begin
				mem_we_q    <= 1'b1;
				mem_addr_q  <= {status[`ST_IRP], indirect_pointer};
				mem_wdata_q <= acc_wdata;
			end
		end
	end

	// program counter; low-byte writes take upper bits from latch, jumps take only bits 12:11 from it
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc_q <= `PC_ZERO;
		end else if (other_rst) begin
			pc_q <= `PC_ZERO;
		end else if (wr_pcl) begin
			// [RULE3] latch supplies pc high bits on low byte write
			pc_q <= pc_from_write;
		end else if (pc_jump) begin
			// [RULE3] latch supplies page on jump
			pc_q <= pc_from_jump;
		end else if (pc_inc) begin
			pc_q <= pc_step;
		end
	end

endmodule

// ===== bench/sfr_bank0_asserts.sv
`timescale 1ns/1ps
module sfr_bank0_checker (
	input logic         clk,
	input logic         nrst,
	input logic         external_reset_pin,
	input logic         watchdog_timeout,
	input logic [6:0]   acc_addr,
	input logic         acc_rd,
	input logic         acc_wr,
	input logic [7:0]   acc_wdata,
	input logic [7:0]   rd_data_q,
	input logic         rd_valid_q,
	input logic [8:0]   mem_addr_q,
	input logic         mem_re_q,
	input logic [7:0]   mem_rdata,
	input logic [12:0]  pc_q,
	input logic         pc_jump,
	input logic [10:0]  pc_jump_target,
	input logic [39:0]  port_pins,
	input logic         timer1_load,
	input logic         rx_load,
	input logic [255:0] sfr_image_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire go = !external_reset_pin && !watchdog_timeout;
	wire b0 = sfr_image_q[30:29] == 2'b00;
	AST_UNMAPPED_ZERO: assert property (
		acc_rd && go && b0 && acc_addr[6:1] == 6'h0f |=> rd_valid_q && rd_data_q == 8'h00)
		else $error("unmapped read not zero");
	AST_RESERVED_BIT: assert property (
		acc_wr && go && b0 && acc_addr == 7'h12 |=> !sfr_image_q[151])
		else $error("unused bit took a write");
	AST_CORE_MIRROR: assert property (
		acc_rd && go && acc_addr == 7'h04 |=> rd_valid_q && rd_data_q == $past(sfr_image_q[39:32]))
		else $error("pointer not seen in every bank");
	AST_PC_LOW_WRITE: assert property (
		acc_wr && go && acc_addr == 7'h02 |=> pc_q == {$past(sfr_image_q[84:80]), $past(acc_wdata)})
		else $error("pc low write lost latch bits");
	AST_PC_JUMP: assert property (
		pc_jump && go && !(acc_wr && acc_addr == 7'h02)
		|=> pc_q == {$past(sfr_image_q[84:83]), $past(pc_jump_target)})
		else $error("jump target wrong");
	AST_OTHER_RESET: assert property (
		!go && !timer1_load |=> sfr_image_q[87:80] == 8'h00
		&& sfr_image_q[119:112] == $past(sfr_image_q[119:112]))
		else $error("other reset values wrong");
	AST_TIMER1_BYTES: assert property (
		acc_wr && go && b0 && acc_addr == 7'h0e && !timer1_load
		|=> sfr_image_q[119:112] == $past(acc_wdata) && $stable(sfr_image_q[127:120]))
		else $error("timer1 bytes not independent");
	AST_USART_CLEAR: assert property (
		!go && !rx_load |=> sfr_image_q[215:200] == 16'h0000)
		else $error("usart data not cleared");
	AST_INDIRECT_READ: assert property (
		acc_rd && go && acc_addr == 7'h00
		|=> mem_re_q && mem_addr_q == {$past(sfr_image_q[31]), $past(sfr_image_q[39:32])}
		##1 rd_valid_q && rd_data_q == $past(mem_rdata))
		else $error("indirect read wrong");
	AST_PORT_PINS: assert property (
		acc_rd && go && b0 && acc_addr == 7'h06 |=> rd_data_q == $past(port_pins[15:8]))
		else $error("port read not from pins");
	cover property (acc_rd && go && acc_addr == 7'h00);
	cover property (!go);
	cover property (pc_jump && go);
endmodule

bind special_function_register_bank0 sfr_bank0_checker sfr_bank0_checker_i (
	.clk, .nrst, .external_reset_pin, .watchdog_timeout, .acc_addr, .acc_rd, .acc_wr,
	.acc_wdata, .rd_data_q, .rd_valid_q, .mem_addr_q, .mem_re_q, .mem_rdata, .pc_q,
	.pc_jump, .pc_jump_target, .port_pins, .timer1_load, .rx_load, .sfr_image_q);

// ===== bench/data_mem_model.sv
`timescale 1ns/1ps
module data_mem_model (
	input logic        clk,
	input logic [8:0]  mem_addr_q,
	input logic        mem_re_q,
	input logic        mem_we_q,
	input logic [7:0]  mem_wdata_q,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:511];
	logic [7:0] junk = 8'h5a;
	always @(posedge clk) begin
		junk <= ~junk;
		if (mem_we_q)
			mem[mem_addr_q] <= mem_wdata_q;
	end
	// data is a toggling junk byte unless a read strobe is up
	assign mem_rdata = mem_re_q ? mem[mem_addr_q] : junk;
endmodule

// ===== bench/special_function_register_bank0_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module special_function_register_bank0_tb_top;
	logic clk = 1'b0, nrst = 1'b0, external_reset_pin = 1'b0, watchdog_timeout = 1'b0;
	logic acc_rd = 1'b0, acc_wr = 1'b0, pc_inc = 1'b0, pc_jump = 1'b0, alu_flags_we = 1'b0;
	logic sleep_entered = 1'b0, watchdog_cleared = 1'b0, peripheral_irq_flags2_set = 1'b0, timer0_load = 1'b0;
	logic timer1_load = 1'b0, timer2_load = 1'b0, serial_load = 1'b0, rx_load = 1'b0;
	logic [6:0] acc_addr = '0;
	logic [7:0] acc_wdata = '0, peripheral_irq_flags1_set = '0, timer0_value = '0, timer2_value = '0;
	logic [7:0] serial_data = '0, rx_data = '0, rd_data_q, mem_wdata_q, mem_rdata;
	logic [2:0] alu_flags = '0, rx_err = '0;
	logic [10:0] pc_jump_target = '0;
	logic [15:0] timer1_value = '0;
	logic [39:0] port_pins = '0;
	logic [8:0] mem_addr_q;
	logic [12:0] pc_q;
	logic [255:0] sfr_image_q;
	logic rd_valid_q, mem_re_q, mem_we_q, tx_written_q;
	logic [6:0] wa [6] = '{7'h10, 7'h12, 7'h0d, 7'h17, 7'h1a, 7'h1e};
	logic [7:0] we [6] = '{8'h3f, 8'h7f, 8'h01, 8'h3f, 8'h00, 8'h00};
	int bad_count = 0;
	int checked = 0;

	special_function_register_bank0 special_function_register_bank0_i (.clk, .nrst,
		.external_reset_pin, .watchdog_timeout, .acc_addr, .acc_rd, .acc_wr, .acc_wdata,
		.rd_data_q, .rd_valid_q, .mem_addr_q, .mem_re_q, .mem_we_q, .mem_wdata_q, .mem_rdata,
		.pc_q, .pc_inc, .pc_jump, .pc_jump_target, .alu_flags_we, .alu_flags, .sleep_entered,
		.watchdog_cleared, .port_pins, .peripheral_irq_flags1_set, .peripheral_irq_flags2_set, .timer0_load, .timer0_value,
		.timer1_load, .timer1_value, .timer2_load, .timer2_value, .serial_load, .serial_data,
		.rx_load, .rx_data, .rx_err, .tx_written_q, .sfr_image_q);
	data_mem_model data_mem_model_i (.clk, .mem_addr_q, .mem_re_q, .mem_we_q, .mem_wdata_q,
		.mem_rdata);

	always #5 clk = ~clk;

	task tick;
		@(posedge clk);
		#1;
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		acc_addr <= a;
		acc_wdata <= d;
		acc_wr <= 1'b1;
		@(posedge clk);
		acc_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [6:0] a, input logic [7:0] e, input logic v = 1'b1);
		acc_addr <= a;
		acc_rd <= 1'b1;
		@(posedge clk);
		acc_rd <= 1'b0;
		#1;
		repeat (2) if (rd_valid_q !== 1'b1) tick;
		`CHK("valid", v, rd_valid_q)
		if (v) `CHK("rdata", e, rd_data_q)
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		// brown-out flag sits outside bank 0, never written here
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		tick;
		for (int a = 1; a < 32; a++) rd(a[6:0], (a == 3) ? 8'h18 : 8'h00);
		port_pins <= 40'ha5_11_22_33_ff;
		wr(7'h06, 8'h3c);
		rd(7'h05, 8'h3f);
		rd(7'h06, 8'h33);
		rd(7'h09, 8'h05);
		`CHK("latch", 8'h3c, sfr_image_q[55:48])
		foreach (wa[i]) begin
			wr(wa[i], 8'hff);
			rd(wa[i], we[i]);
		end
		wr(7'h0e, 8'h12);
		wr(7'h0f, 8'h34);
		rd(7'h0e, 8'h12);
		rd(7'h0f, 8'h34);
		wr(7'h04, 8'h40);
		wr(7'h00, 8'h77);
		rd(7'h00, 8'h77);
		`CHK("mem", 8'h77, data_mem_model_i.mem[9'h040])
		wr(7'h03, 8'h20);
		rd(7'h04, 8'h40);
		rd(7'h0e, 8'h00, 1'b0);
		wr(7'h0a, 8'hff);
		wr(7'h03, 8'h00);
		rd(7'h0a, 8'h1f);
		wr(7'h02, 8'h5a);
		`CHK("pc", 13'h1f5a, pc_q)
		pc_jump_target <= 11'h123;
		pc_jump <= 1'b1;
		peripheral_irq_flags1_set <= 8'h81;
		alu_flags_we <= 1'b1;
		alu_flags <= 3'h5;
		rx_data <= 8'hc3;
		rx_load <= 1'b1;
		tick;
		pc_jump <= 1'b0;
		peripheral_irq_flags1_set <= 8'h00;
		alu_flags_we <= 1'b0;
		rx_load <= 1'b0;
		`CHK("pc", 13'h1923, pc_q)
		rd(7'h0c, 8'h81);
		rd(7'h03, 8'h1d);
		rd(7'h1a, 8'hc3);
		wr(7'h19, 8'h99);
		`CHK("txw", 1'b1, tx_written_q)
		watchdog_timeout <= 1'b1;
		tick;
		watchdog_timeout <= 1'b0;
		rd(7'h1a, 8'h00);
		`CHK("txdata", 8'h00, sfr_image_q[207:200])
		rd(7'h03, 8'h0d);
		rd(7'h0a, 8'h00);
		rd(7'h0e, 8'h12);
		sleep_entered <= 1'b1;
		pc_inc <= 1'b1;
		timer0_load <= 1'b1;
		timer0_value <= 8'h6b;
		tick;
		sleep_entered <= 1'b0;
		pc_inc <= 1'b0;
		timer0_load <= 1'b0;
		`CHK("pc", 13'h0001, pc_q)
		rd(7'h03, 8'h15);
		rd(7'h01, 8'h6b);
		watchdog_cleared <= 1'b1;
		tick;
		watchdog_cleared <= 1'b0;
		rd(7'h03, 8'h1d);
		external_reset_pin <= 1'b1;
		tick;
		external_reset_pin <= 1'b0;
		rd(7'h10, 8'h3f);
		rd(7'h0d, 8'h00);
		rd(7'h04, 8'h40);
		nrst <= 1'b0;
		tick;
		nrst <= 1'b1;
		rd(7'h0e, 8'h00);
		rd(7'h03, 8'h18);
		report_and_stop;
	end

	initial begin
		#50000;
		bad_count++;
		report_and_stop;
	end
endmodule
